// *** inc/adc_serial_consts.svh ***
// constants for the serial output word port: fields, opcodes, timing
`ifndef ADC_SERIAL_CONSTS_SVH
`define ADC_SERIAL_CONSTS_SVH

// ----------------------------------------------------------------
// word layout
// ----------------------------------------------------------------
`define WORD_W          32
`define RESULT_W        18
`define RESULT_LSB      14
`define CHAIN_ID_W      4
`define SUPPLY_ALARM_W  2
`define INPUT_ALARM_W   2
`define RANGE_W         4
`define PARITY_W        2
`define REG_ADDR_W      9
`define REG_DATA_W      16

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define OP_MSB          31
`define OP_LSB          27
`define ADDR_MSB        24
`define ADDR_LSB        16
`define OP_HWORD_READ   5'h19
`define OP_BYTE_READ    5'h09
`define MIN_FRAME_CLKS  6'h20

// ----------------------------------------------------------------
// reset values and fixed data
// ----------------------------------------------------------------
`define MODE_RESET      2'h0
`define FIXED_PATTERN   32'ha5a5_5a5a

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_CLK_NS        4
`define INT_CLK_HALF_NS   20
`define INT_CLK_HALF_CYC  (`INT_CLK_HALF_NS / `SYS_CLK_NS)

`endif

// *** inc/adc_serial_pkg.sv ***
// types shared by the serial output word port
package adc_serial_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FRAME  = 2'b01,
    ST_DECODE = 2'b10
  } frame_state_type;

  typedef enum logic [1:0] {
    KIND_CONV  = 2'b00,
    KIND_BYTE  = 2'b01,
    KIND_HWORD = 2'b10
  } word_kind_type;

  typedef struct packed {
    logic [3:0] chain_id;
    logic [1:0] supply_alarm;
    logic [1:0] input_alarm;
    logic [3:0] range_code;
  } flag_fields_type;

endpackage

// *** inc/link_capture_if.sv ***
// carrier for the words captured on the serial clock
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_consts.svh"

interface link_capture_if;
  logic [`WORD_W-1:0] rise_word;
  logic [`WORD_W-1:0] fall_word;

  modport capture (
    output rise_word,
    output fall_word
  );
  modport core (
    input rise_word,
    input fall_word
  );
endinterface

`default_nettype wire

// *** rtl/link_capture.sv ***
// input shift registers clocked by the host's serial clock
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_consts.svh"

module link_capture (
  input  wire logic        sclk,
  input  wire logic        serial_in,
  link_capture_if.capture  cap
);

  // ----------------------------------------------------------------
  // both edges always capture; the core picks one by clock mode
  // ----------------------------------------------------------------
  // avoids muxing the clock itself; only the last 32 bits survive
  logic [`WORD_W-1:0] rise_r;
  logic [`WORD_W-1:0] rise_nxt;
  logic [`WORD_W-1:0] fall_r;
  logic [`WORD_W-1:0] fall_nxt;

  always_comb begin
    rise_nxt = {rise_r[`WORD_W-2:0], serial_in};
    fall_nxt = {fall_r[`WORD_W-2:0], serial_in};
  end

  always_ff @(posedge sclk) begin
    rise_r <= rise_nxt;
  end

  always_ff @(negedge sclk) begin
    fall_r <= fall_nxt;
  end

  assign cap.rise_word = rise_r;
  assign cap.fall_word = fall_r;

endmodule

`default_nettype wire

// *** rtl/adc_serial_output_word_port.sv ***
// serial port core: output word assembly, clock modes, command capture
// ----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_consts.svh"

module adc_serial_output_word_port (
  input  wire logic                      SYS_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic                      SERIAL_CLK,
  input  wire logic                      CONVERT_SELECT_N,
  input  wire logic                      SERIAL_IN,
  output var  logic                      SERIAL_OUT,
  output var  logic                      READY_STROBE,
  input  wire logic [2:0]                OUTPUT_PATTERN_SELECT,
  input  wire logic                      CHAIN_ID_APPEND_EN,
  input  wire logic                      SUPPLY_ALARM_APPEND_EN,
  input  wire logic                      INPUT_ALARM_APPEND_EN,
  input  wire logic                      RANGE_APPEND_EN,
  input  wire logic                      PARITY_APPEND_EN,
  input  wire logic [1:0]                WRITE_CLOCK_MODE_SELECT,
  input  wire logic [1:0]                READ_PROTOCOL_SELECT,
  input  wire logic                      OUT_CLK_INTERNAL,
  input  wire logic [`RESULT_W-1:0]      CONV_RESULT,
  input  wire logic                      CONV_VALID,
  input  wire logic [`CHAIN_ID_W-1:0]    CHAIN_ID,
  input  wire logic [`SUPPLY_ALARM_W-1:0] SUPPLY_ALARM,
  input  wire logic [`INPUT_ALARM_W-1:0] INPUT_ALARM,
  input  wire logic [`RANGE_W-1:0]       RANGE_CODE,
  input  wire logic [`REG_DATA_W-1:0]    REG_RDATA,
  output var  logic [`REG_ADDR_W-1:0]    REG_ADDR,
  output var  logic [`WORD_W-1:0]        CMD_WORD,
  output var  logic                      CMD_VALID,
  output var  logic [1:0]                ACTIVE_CLOCK_MODE
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // modes 0 and 3 capture on rising, 1 and 2 on falling
  function automatic logic cap_on_rise(input logic [1:0] mode);
    cap_on_rise = ~(mode[0] ^ mode[1]);
  endfunction

  // result on top, enabled flags packed below, zeros fill the rest
  function automatic logic [`WORD_W-1:0] build_word(
    input logic [`RESULT_W-1:0]        res,
    input logic [4:0]                  en,
    input adc_serial_pkg::flag_fields_type f
  );
    logic [`WORD_W-1:0] w;
    int                 pos;
    logic [1:0]         par;
    w   = {res, 14'h0000};
    pos = `RESULT_LSB;
    par = 2'h0;
    if (en[4]) begin
      pos = pos - `CHAIN_ID_W;
      w[pos +: `CHAIN_ID_W] = f.chain_id;
    end
    if (en[3]) begin
      pos = pos - `SUPPLY_ALARM_W;
      w[pos +: `SUPPLY_ALARM_W] = f.supply_alarm;
    end
    if (en[2]) begin
      pos = pos - `INPUT_ALARM_W;
      w[pos +: `INPUT_ALARM_W] = f.input_alarm;
    end
    if (en[1]) begin
      pos = pos - `RANGE_W;
      w[pos +: `RANGE_W] = f.range_code;
    end
    if (en[0]) begin
      // parity over result alone, then over result plus flags
      par = {^res, ^w};
      pos = pos - `PARITY_W;
      w[pos +: `PARITY_W] = par;
    end
    build_word = w;
  endfunction

  // ----------------------------------------------------------------
  // link side capture
  // ----------------------------------------------------------------
  link_capture_if cap_if ();

  link_capture u_capture (
    .sclk      (SERIAL_CLK),
    .serial_in (SERIAL_IN),
    .cap       (cap_if.capture)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_m_r;
  logic sclk_s_r;
  logic sclk_d_r;
  logic cs_m_r;
  logic cs_s_r;
  logic cs_d_r;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      cs_m_r   <= 1'b1;
      cs_s_r   <= 1'b1;
      cs_d_r   <= 1'b1;
    end else begin
      sclk_m_r <= SERIAL_CLK;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      cs_m_r   <= CONVERT_SELECT_N;
      cs_s_r   <= cs_m_r;
      cs_d_r   <= cs_s_r;
    end
  end

  always_comb begin
    sclk_rise = sclk_s_r & ~sclk_d_r;
    sclk_fall = ~sclk_s_r & sclk_d_r;
    cs_fall   = ~cs_s_r & cs_d_r;
    cs_rise   = cs_s_r & ~cs_d_r;
  end

  // ----------------------------------------------------------------
  // frame control state
  // ----------------------------------------------------------------
  adc_serial_pkg::frame_state_type state_r;
  adc_serial_pkg::frame_state_type state_nxt;
  adc_serial_pkg::word_kind_type   kind_r;
  adc_serial_pkg::word_kind_type   kind_nxt;
  logic [1:0]               mode_r;
  logic [1:0]               mode_nxt;
  logic                     int_sel_r;
  logic                     int_sel_nxt;
  logic [5:0]               count_r;
  logic [5:0]               count_nxt;
  logic [`REG_ADDR_W-1:0]   addr_r;
  logic [`REG_ADDR_W-1:0]   addr_nxt;
  logic [`WORD_W-1:0]       cmd_word_r;
  logic [`WORD_W-1:0]       cmd_word_nxt;
  logic                     cmd_valid_r;
  logic                     cmd_valid_nxt;
  logic [`RESULT_W-1:0]     result_r;
  logic [`RESULT_W-1:0]     result_nxt;
  logic [`WORD_W-1:0]       cmd_in;
  logic [4:0]               opcode;
  logic                     long_frame;
  logic                     cap_ev;

  always_comb begin
    state_nxt     = state_r;
    kind_nxt      = kind_r;
    mode_nxt      = mode_r;
    int_sel_nxt   = int_sel_r;
    count_nxt     = count_r;
    addr_nxt      = addr_r;
    cmd_word_nxt  = cmd_word_r;
    cmd_valid_nxt = 1'b0;
    result_nxt    = CONV_VALID ? CONV_RESULT : result_r;
    cmd_in        = cap_on_rise(mode_r) ? cap_if.rise_word
                                        : cap_if.fall_word;
    opcode        = cmd_in[`OP_MSB:`OP_LSB];
    long_frame    = (count_r >= `MIN_FRAME_CLKS);
    cap_ev        = cap_on_rise(mode_r) ? sclk_rise : sclk_fall;
    case (state_r)
      adc_serial_pkg::ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = adc_serial_pkg::ST_FRAME;
          count_nxt = 6'h00;
        end else begin
          // mode only changes between frames
          mode_nxt    = WRITE_CLOCK_MODE_SELECT;
          int_sel_nxt = (READ_PROTOCOL_SELECT != 2'h0)
                        & OUT_CLK_INTERNAL;
        end
      end
      adc_serial_pkg::ST_FRAME: begin
        if (cs_rise) begin
          state_nxt = adc_serial_pkg::ST_DECODE;
        end else if (cap_ev && !long_frame) begin
          count_nxt = count_r + 6'h01;
        end
      end
      adc_serial_pkg::ST_DECODE: begin
        state_nxt = adc_serial_pkg::ST_IDLE;
        kind_nxt  = adc_serial_pkg::KIND_CONV;
        if (long_frame) begin
          // write commands go to the register file only here
          cmd_word_nxt  = cmd_in;
          cmd_valid_nxt = 1'b1;
          addr_nxt      = cmd_in[`ADDR_MSB:`ADDR_LSB];
          if (opcode == `OP_HWORD_READ) begin
            kind_nxt = adc_serial_pkg::KIND_HWORD;
            addr_nxt = {cmd_in[`ADDR_MSB:`ADDR_LSB+1], 1'b0};
          end else if (opcode == `OP_BYTE_READ) begin
            kind_nxt = adc_serial_pkg::KIND_BYTE;
          end
        end
      end
      default: begin
        state_nxt = adc_serial_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_r     <= adc_serial_pkg::ST_IDLE;
      kind_r      <= adc_serial_pkg::KIND_CONV;
      mode_r      <= `MODE_RESET;
      int_sel_r   <= 1'b0;
      count_r     <= 6'h00;
      addr_r      <= 9'h000;
      cmd_word_r  <= 32'h0000_0000;
      cmd_valid_r <= 1'b0;
      result_r    <= 18'h00000;
    end else begin
      state_r     <= state_nxt;
      kind_r      <= kind_nxt;
      mode_r      <= mode_nxt;
      int_sel_r   <= int_sel_nxt;
      count_r     <= count_nxt;
      addr_r      <= addr_nxt;
      cmd_word_r  <= cmd_word_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      result_r    <= result_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output word selection
  // ----------------------------------------------------------------
  logic [`WORD_W-1:0]              out_word;
  adc_serial_pkg::flag_fields_type flags;
  logic [4:0]                      append_en;

  always_comb begin
    flags.chain_id     = CHAIN_ID;
    flags.supply_alarm = SUPPLY_ALARM;
    flags.input_alarm  = INPUT_ALARM;
    flags.range_code   = RANGE_CODE;
    append_en = {CHAIN_ID_APPEND_EN, SUPPLY_ALARM_APPEND_EN,
                 INPUT_ALARM_APPEND_EN, RANGE_APPEND_EN,
                 PARITY_APPEND_EN};
    if (OUTPUT_PATTERN_SELECT[2]) begin
      out_word = `FIXED_PATTERN;
    end else if (kind_r == adc_serial_pkg::KIND_BYTE) begin
      out_word = {addr_r[0] ? REG_RDATA[15:8] : REG_RDATA[7:0],
                  24'h00_0000};
    end else if (kind_r == adc_serial_pkg::KIND_HWORD) begin
      out_word = {REG_RDATA, 16'h0000};
    end else begin
      out_word = build_word(result_r, append_en, flags);
    end
  end

  // ----------------------------------------------------------------
  // output shift register and lane
  // ----------------------------------------------------------------
  // the lane lags the pin edges by the sync depth, a few sys cycles;
  // fine against the half period of the serial clock
  logic [`WORD_W-1:0] sh_r;
  logic [`WORD_W-1:0] sh_nxt;
  logic               sdo_r;
  logic               sdo_nxt;
  logic               rvs_r;
  logic               rvs_nxt;
  logic [3:0]         div_r;
  logic [3:0]         div_nxt;
  logic               launch_ev;
  logic               int_tick;

  always_comb begin
    sh_nxt    = sh_r;
    sdo_nxt   = sdo_r;
    rvs_nxt   = 1'b0;
    div_nxt   = 4'h0;
    int_tick  = (div_r == 4'(`INT_CLK_HALF_CYC - 1));
    // launch is the edge opposite capture
    launch_ev = cap_on_rise(mode_r) ? sclk_fall : sclk_rise;
    if (state_r == adc_serial_pkg::ST_FRAME && int_sel_r) begin
      // internal clock times the data; strobe shows that clock
      div_nxt   = int_tick ? 4'h0 : div_r + 4'h1;
      rvs_nxt   = int_tick ? ~rvs_r : rvs_r;
      launch_ev = int_tick & ~rvs_r;
    end
    if (state_r == adc_serial_pkg::ST_IDLE && cs_fall) begin
      if (!mode_r[0]) begin
        // msb already out at select fall
        sdo_nxt = out_word[`WORD_W-1];
        sh_nxt  = {out_word[`WORD_W-2:0], 1'b0};
      end else begin
        sdo_nxt = 1'b0;
        sh_nxt  = out_word;
      end
    end else if (state_r == adc_serial_pkg::ST_FRAME) begin
      if (cs_rise) begin
        sdo_nxt = 1'b0;
      end else if (launch_ev) begin
        // short frames simply stop early; bits sent stay valid
        sdo_nxt = sh_r[`WORD_W-1];
        sh_nxt  = {sh_r[`WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sh_r  <= 32'h0000_0000;
      sdo_r <= 1'b0;
      rvs_r <= 1'b0;
      div_r <= 4'h0;
    end else begin
      sh_r  <= sh_nxt;
      sdo_r <= sdo_nxt;
      rvs_r <= rvs_nxt;
      div_r <= div_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SERIAL_OUT        = sdo_r;
  assign READY_STROBE      = rvs_r;
  assign REG_ADDR          = addr_r;
  assign CMD_WORD          = cmd_word_r;
  assign CMD_VALID         = cmd_valid_r;
  assign ACTIVE_CLOCK_MODE = mode_r;

endmodule

`default_nettype wire

// *** test/adc_port_chk.sv ***
// assertion checker for the serial output word port
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_consts.svh"

module adc_port_chk (
  input  wire logic                   SYS_CLK,
  input  wire logic                   SYS_RST,
  input  wire logic                   CONVERT_SELECT_N,
  input  wire logic                   SERIAL_OUT,
  input  wire logic                   READY_STROBE,
  input  wire logic [1:0]             WRITE_CLOCK_MODE_SELECT,
  input  wire logic [1:0]             READ_PROTOCOL_SELECT,
  input  wire logic [`REG_ADDR_W-1:0] REG_ADDR,
  input  wire logic [`WORD_W-1:0]     CMD_WORD,
  input  wire logic                   CMD_VALID,
  input  wire logic [1:0]             ACTIVE_CLOCK_MODE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RESET_STATE: assert property (
    $fell(SYS_RST) |-> ACTIVE_CLOCK_MODE == 2'h0 && !CMD_VALID
      && !SERIAL_OUT && !READY_STROBE)
    else $error("outputs not cleared by reset");
  AST_LANE_IDLE: assert property (
    CONVERT_SELECT_N [*6] |-> !SERIAL_OUT)
    else $error("lane not zero between frames");
  AST_CMD_AFTER_FRAME: assert property (
    CMD_VALID |-> CONVERT_SELECT_N && $past(CONVERT_SELECT_N, 2))
    else $error("command taken inside a frame");
  AST_CMD_PULSE: assert property (
    CMD_VALID |=> !CMD_VALID)
    else $error("command strobe longer than one cycle");
  AST_HWORD_ADDR: assert property (
    CMD_VALID && CMD_WORD[31:27] == `OP_HWORD_READ
      |-> REG_ADDR == {CMD_WORD[24:17], 1'b0})
    else $error("halfword address bit zero not cleared");
  AST_BYTE_ADDR: assert property (
    CMD_VALID && CMD_WORD[31:27] == `OP_BYTE_READ
      |-> REG_ADDR == CMD_WORD[24:16])
    else $error("byte read address wrong");
  AST_MODE_HELD: assert property (
    !CONVERT_SELECT_N [*4] |-> $stable(ACTIVE_CLOCK_MODE))
    else $error("clock mode changed inside a frame");
  AST_MODE_ADOPT: assert property (
    $fell(CONVERT_SELECT_N)
      |-> ##6 ACTIVE_CLOCK_MODE == $past(WRITE_CLOCK_MODE_SELECT, 6))
    else $error("frame not run in selected clock mode");
  AST_STROBE_SPI: assert property (
    (READ_PROTOCOL_SELECT == 2'h0) [*4] |-> !READY_STROBE)
    else $error("ready strobe active in spi read");
  AST_CMD_HOLD: assert property (
    !CMD_VALID |-> $stable(CMD_WORD) && $stable(REG_ADDR))
    else $error("command word changed without strobe");

  cover property (CMD_VALID && CMD_WORD[31:27] == `OP_BYTE_READ);
  cover property (CMD_VALID && CMD_WORD[31:27] == `OP_HWORD_READ);
  cover property (ACTIVE_CLOCK_MODE == 2'h3 && !CONVERT_SELECT_N);
  cover property ($rose(READY_STROBE));
endmodule

`default_nettype wire

// *** test/host_link_model.sv ***
// host controller model: drives serial clock, select and data in
`timescale 1ns/100ps
`default_nettype none

module host_link_model (
  output var  logic sclk,
  output var  logic sel_n,
  output var  logic din,
  input  wire logic dout
);
  localparam realtime HALF = 40.0;

  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    din = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame of n clocks; the last 32 bits carry the command
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] cmd, input int n,
                      input logic [1:0] mode, output logic [31:0] got);
    int j;
    got = '0;
    sclk = mode[1];
    // odd offset keeps link edges off the system clock phase
    #(HALF + 1.3) sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      j = n - 1 - i;
      if (!mode[0]) din = (j < 32) ? cmd[j] : 1'b0;
      #(HALF);
      if (!mode[0] && i < 32) got[31-i] = dout;
      sclk = ~sclk;
      if (mode[0]) din = (j < 32) ? cmd[j] : 1'b0;
      #(HALF);
      if (mode[0] && i < 32) got[31-i] = dout;
      sclk = ~sclk;
    end
    #(HALF) sel_n = 1'b1;
    // released line is driven to the inverse of the last bit
    din = ~din;
    #(2 * HALF);
  endtask
endmodule

`default_nettype wire

// *** test/adc_serial_output_word_port_bench.sv ***
// self-checking bench for the serial output word port
`timescale 1ns/100ps
`default_nettype none
`include "adc_serial_consts.svh"

module adc_serial_output_word_port_bench;
  logic        SYS_CLK, SYS_RST, SERIAL_CLK, CONVERT_SELECT_N, SERIAL_IN;
  logic        SERIAL_OUT, READY_STROBE, CMD_VALID, CONV_VALID;
  logic        OUT_CLK_INTERNAL;
  logic [2:0]  OUTPUT_PATTERN_SELECT;
  logic [1:0]  WRITE_CLOCK_MODE_SELECT, READ_PROTOCOL_SELECT;
  logic [1:0]  ACTIVE_CLOCK_MODE, SUPPLY_ALARM, INPUT_ALARM, mode;
  logic [17:0] CONV_RESULT;
  logic [3:0]  CHAIN_ID, RANGE_CODE;
  logic [15:0] REG_RDATA;
  logic [8:0]  REG_ADDR;
  logic [31:0] CMD_WORD, got;
  logic [4:0]  app_en;
  logic        strobe_seen = 1'b0;
  int          mismatches = 0, samples_checked = 0, cmd_cnt = 0, cycles = 0;

  // ----------------------------------------------------------------
  // design, host and register file stand-in
  // ----------------------------------------------------------------
  adc_serial_output_word_port dut (
    .SYS_CLK, .SYS_RST, .SERIAL_CLK, .CONVERT_SELECT_N, .SERIAL_IN,
    .SERIAL_OUT, .READY_STROBE, .OUTPUT_PATTERN_SELECT,
    .CHAIN_ID_APPEND_EN(app_en[4]), .SUPPLY_ALARM_APPEND_EN(app_en[3]),
    .INPUT_ALARM_APPEND_EN(app_en[2]), .RANGE_APPEND_EN(app_en[1]),
    .PARITY_APPEND_EN(app_en[0]), .WRITE_CLOCK_MODE_SELECT,
    .READ_PROTOCOL_SELECT, .OUT_CLK_INTERNAL, .CONV_RESULT, .CONV_VALID,
    .CHAIN_ID, .SUPPLY_ALARM, .INPUT_ALARM, .RANGE_CODE, .REG_RDATA,
    .REG_ADDR, .CMD_WORD, .CMD_VALID, .ACTIVE_CLOCK_MODE);

  host_link_model host (.sclk(SERIAL_CLK), .sel_n(CONVERT_SELECT_N),
                        .din(SERIAL_IN), .dout(SERIAL_OUT));

  function automatic logic [15:0] rv(input logic [8:0] a);
    return {a[7:0] ^ 8'h5c, a[7:0] ^ 8'hc5};
  endfunction

  assign REG_RDATA = rv(REG_ADDR);

  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  always @(posedge SYS_CLK) begin
    cycles++;
    if (CMD_VALID === 1'b1) cmd_cnt++;
    if (READY_STROBE === 1'b1) strobe_seen <= 1'b1;
    // every test together needs about 36000 cycles
    if (cycles == 60000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // expectations and access tasks
  // ----------------------------------------------------------------
  // a function, so that conv_word may call it
  function automatic void put(inout logic [13:0] t, inout int n,
                              input logic [3:0] v, input int w);
    t = (t << w) | 14'(v);
    n += w;
  endfunction

  function automatic logic [31:0] conv_word(input logic [4:0] en);
    logic [13:0] t;
    int          n;
    logic        p;
    t = '0;
    n = 0;
    p = ^CONV_RESULT ^ (en[4] & ^CHAIN_ID) ^ (en[3] & ^SUPPLY_ALARM)
        ^ (en[2] & ^INPUT_ALARM) ^ (en[1] & ^RANGE_CODE);
    if (en[4]) put(t, n, CHAIN_ID, 4);
    if (en[3]) put(t, n, {2'h0, SUPPLY_ALARM}, 2);
    if (en[2]) put(t, n, {2'h0, INPUT_ALARM}, 2);
    if (en[1]) put(t, n, RANGE_CODE, 4);
    if (en[0]) put(t, n, {2'h0, ^CONV_RESULT, p}, 2);
    return {CONV_RESULT, 14'(t << (14 - n))};
  endfunction

  function automatic logic [31:0] rdb(input logic [8:0] a);
    logic [15:0] v;
    v = rv(a);
    return {a[0] ? v[15:8] : v[7:0], 24'h0};
  endfunction

  function automatic logic [31:0] rdh(input logic [8:0] a);
    return {rv({a[8:1], 1'b0}), 16'h0};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp, seen);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic frame(input logic [31:0] cmd, input int n);
    host.xfer(cmd, n, mode, got);
    tick(1);
  endtask

  // command frame, then a frame that returns its answer
  task automatic rd(input logic [4:0] op, input logic [8:0] a,
                    input int n, input logic [31:0] exp);
    int c;
    c = cmd_cnt;
    frame({op, 2'b00, a, 16'h0}, n);
    check("command count", 32'(c + (n >= 32)), 32'(cmd_cnt));
    if (n >= 32) begin
      check("address", {23'h0, op == 5'h19 ? {a[8:1], 1'b0} : a},
            {23'h0, REG_ADDR});
      check("command word", {op, 2'b00, a, 16'h0}, CMD_WORD);
    end
    frame(32'h0, 32);
    check("output word", exp, got);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    static logic [4:0] ens [5] = '{5'h1f, 5'h0b, 5'h00, 5'h14, 5'h01};
    SYS_RST = 1'b1;
    CONV_VALID = 1'b0;
    OUT_CLK_INTERNAL = 1'b0;
    OUTPUT_PATTERN_SELECT = 3'h0;
    WRITE_CLOCK_MODE_SELECT = 2'h0;
    READ_PROTOCOL_SELECT = 2'h0;
    mode = 2'h0;
    app_en = 5'h1f;
    CONV_RESULT = 18'h2d3b6;
    CHAIN_ID = 4'h9;
    SUPPLY_ALARM = 2'h2;
    INPUT_ALARM = 2'h1;
    RANGE_CODE = 4'h6;
    tick(3);
    SYS_RST = 1'b0;
    tick(4);
    check("mode", 32'h0, {30'h0, ACTIVE_CLOCK_MODE});
    check("lane", 32'h0, {31'h0, SERIAL_OUT});
    CONV_VALID = 1'b1;
    tick(1);
    CONV_VALID = 1'b0;
    done("reset");
    foreach (ens[i]) begin
      app_en = ens[i];
      rd(5'h0, 9'h0, 32, conv_word(ens[i]));
    end
    done("flag packing");
    app_en = 5'h1f;
    rd(5'h09, 9'h004, 32, rdb(9'h004));
    rd(5'h09, 9'h0c5, 32, rdb(9'h0c5));
    rd(5'h19, 9'h007, 32, rdh(9'h007));
    rd(5'h19, 9'h0aa, 40, rdh(9'h0aa));
    rd(5'h09, 9'h004, 31, conv_word(5'h1f));
    rd(5'h1a, 9'h010, 32, conv_word(5'h1f));
    frame(32'h0, 20);
    check("short frame", conv_word(5'h1f) & 32'hfffff000, got);
    done("register reads");
    for (int p = 4; p < 8; p++) begin
      OUTPUT_PATTERN_SELECT = 3'(p);
      rd(5'h09, 9'h004, 32, `FIXED_PATTERN);
    end
    OUTPUT_PATTERN_SELECT = 3'h3;
    rd(5'h19, 9'h002, 32, rdh(9'h002));
    OUTPUT_PATTERN_SELECT = 3'h0;
    done("pattern select");
    for (int m = 1; m < 4; m++) begin
      frame(32'h0, 32);
      WRITE_CLOCK_MODE_SELECT = 2'(m);
      mode = 2'(m);
      rd(5'h09, 9'h0c5, 32, rdb(9'h0c5));
      check("clock mode", 32'(m), {30'h0, ACTIVE_CLOCK_MODE});
      rd(5'h00, 9'h000, 36, conv_word(5'h1f));
      frame(32'h0, 32);
      WRITE_CLOCK_MODE_SELECT = 2'h0;
      mode = 2'h0;
    end
    done("clock modes");
    check("spi strobe", 32'h0, {31'h0, strobe_seen});
    READ_PROTOCOL_SELECT = 2'h1;
    OUT_CLK_INTERNAL = 1'b1;
    frame(32'h0, 32);
    check("internal strobe", 32'h1, {31'h0, strobe_seen});
    READ_PROTOCOL_SELECT = 2'h0;
    OUT_CLK_INTERNAL = 1'b0;
    done("clock source");
    results();
  end
endmodule

bind adc_serial_output_word_port adc_port_chk chk (
  .SYS_CLK, .SYS_RST, .CONVERT_SELECT_N, .SERIAL_OUT, .READY_STROBE,
  .WRITE_CLOCK_MODE_SELECT, .READ_PROTOCOL_SELECT, .REG_ADDR, .CMD_WORD,
  .CMD_VALID, .ACTIVE_CLOCK_MODE);

`default_nettype wire
